// ---- hw/tocu_top.sv ----
// 8-bit timer with two compare channels, compare outputs and apb registers
//
// The APB slave port and the register addresses were chosen for this implementation.

// What this block does
// - counter compared to both compare values always
// - compare flag set one timer tick later
// - enabled flag raises request, cleared on service
// - writing one clears a flag, zero keeps
// - compare values buffered only in pwm modes
// - buffer loads active value at top only
// - cpu reaches buffer or active value by mode
// - force strobe acts like match in non-pwm modes only, no flag
// - counter write blocks matches for next tick
// - output state survives waveform mode changes
// - output action bits take effect immediately
// - reset clears both output states low
// - nonzero action bits override port output value
// - pin direction still follows port direction bit
// - action zero leaves output state unchanged
// - new action governs next match or force
// - counting depends on waveform mode, not on action bits
// - pwm: polarity; non-pwm: set clear toggle
// - mode zero counts up, wraps ff to 00
// - overflow flag set as counter becomes zero, in ctc only on the wrap from ff to 00
// - mode encodings: 2 ctc, 3/7 fast, 1/5 phase
// - clock select zero stops timer, count accessible
// - cpu counter write beats hardware count
module tocu_top #(
	parameter int CNT_W = 8
) (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	// timer clock enable from prescaler or pin edge
	input wire logic tick_i,
	// apb slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// interrupt requests and service acknowledges: ovf, cmp a, cmp b
	output logic [2:0] irq_o,
	input wire logic [2:0] irq_ack_i,
	// compare pins, enable low while driving
	output logic pin_a_o,
	output logic pin_a_oe_n_o,
	output logic pin_b_o,
	output logic pin_b_oe_n_o
);
	// the register layout is fixed at eight bits
	if (CNT_W != 8) begin : g_chk
		$error("tocu_top: CNT_W must be 8");
	end

	// software registers
	logic [1:0] wgm_lo_q;
	logic wgm_hi_q;
	logic [2:0] clock_source_sel_q;
	logic [1:0] action_a_q;
	logic [1:0] action_b_q;
	logic [2:0] mask_q;
	logic [3:0] pins_q;
	logic [7:0] timer_count_q;
	logic [7:0] timer_count_d;
	logic count_up_q;
	logic count_up_d;
	logic block_q;
	logic [7:0] compare_value_a_q;
	logic [7:0] compare_value_b_q;
	logic [7:0] buf_a_q;
	logic [7:0] buf_b_q;
	logic [2:0] flags_q;
	logic compare_out_state_a_q;
	logic compare_out_state_b_q;
	logic ready_q;

	// decoded state
	logic [2:0] waveform_mode_sel;
	tocu_pkg::tocu_wave_t wave;
	logic pwm;
	logic timer_tick;
	logic [7:0] top;
	logic at_top;
	logic match_a;
	logic match_b;
	logic hit_a;
	logic hit_b;
	logic ovf_evt;
	logic bottom_evt;
	logic wr_en;
	logic cnt_wr;
	logic force_a;
	logic force_b;

	// map the mode field onto a counting family
	function automatic tocu_pkg::tocu_wave_t wave_of(input logic [2:0] m);
		tocu_pkg::tocu_wave_t w;
		w = tocu_pkg::WAVE_NORMAL;
		if (m == tocu_pkg::WGM_CTC) begin
			w = tocu_pkg::WAVE_CTC;
		end else if (m == tocu_pkg::WGM_FAST_FF || m == tocu_pkg::WGM_FAST_OCR) begin
			w = tocu_pkg::WAVE_FAST;
		end else if (m == tocu_pkg::WGM_PHASE_FF || m == tocu_pkg::WGM_PHASE_OCR) begin
			w = tocu_pkg::WAVE_PHASE;
		end
		return w;
	endfunction : wave_of

	// output state after a match; reserved codes keep the state
	function automatic logic oc_next(input logic oc, input logic [1:0] com, input tocu_pkg::tocu_wave_t w,
			input logic up, input logic tog_ok);
		logic r;
		r = oc;
		unique case (w)
			tocu_pkg::WAVE_NORMAL, tocu_pkg::WAVE_CTC: begin
				unique case (com)
					tocu_pkg::COM_OFF: r = oc;
					tocu_pkg::COM_TOGGLE: r = ~oc;
					tocu_pkg::COM_CLEAR: r = 1'b0;
					tocu_pkg::COM_SET: r = 1'b1;
				endcase
			end
			tocu_pkg::WAVE_FAST: begin
				unique case (com)
					tocu_pkg::COM_OFF: r = oc;
					tocu_pkg::COM_TOGGLE: r = tog_ok ? ~oc : oc;
					tocu_pkg::COM_CLEAR: r = 1'b0;
					tocu_pkg::COM_SET: r = 1'b1;
				endcase
			end
			tocu_pkg::WAVE_PHASE: begin
				unique case (com)
					tocu_pkg::COM_OFF: r = oc;
					tocu_pkg::COM_TOGGLE: r = tog_ok ? ~oc : oc;
					tocu_pkg::COM_CLEAR: r = ~up;
					tocu_pkg::COM_SET: r = up;
				endcase
			end
		endcase
		return r;
	endfunction : oc_next

	// mode decode; action bits take no part in counting
	assign waveform_mode_sel = {wgm_hi_q, wgm_lo_q};
	assign wave = wave_of(waveform_mode_sel);
	assign pwm = (wave == tocu_pkg::WAVE_FAST) || (wave == tocu_pkg::WAVE_PHASE);
	assign timer_tick = tick_i && (clock_source_sel_q != tocu_pkg::CS_STOP);
	assign top = (waveform_mode_sel == tocu_pkg::WGM_FAST_OCR || waveform_mode_sel == tocu_pkg::WGM_PHASE_OCR
		|| wave == tocu_pkg::WAVE_CTC) ? compare_value_a_q : tocu_pkg::COUNT_MAX;
	assign at_top = timer_count_q == top;

	// comparators and blocked match events
	assign match_a = timer_count_q == compare_value_a_q;
	assign match_b = timer_count_q == compare_value_b_q;
	assign hit_a = timer_tick && match_a && !block_q;
	assign hit_b = timer_tick && match_b && !block_q;
	assign bottom_evt = timer_tick && (wave == tocu_pkg::WAVE_FAST) && at_top && !cnt_wr;

	// bus strobes; writes land on the access edge
	assign wr_en = psel_i && penable_i && ready_q && pwrite_i;
	assign cnt_wr = wr_en && (paddr_i == tocu_pkg::ADDR_COUNT);
	assign force_a = wr_en && (paddr_i == tocu_pkg::ADDR_CTRL_B) && pwdata_i[tocu_pkg::FORCE_A_POS] && !pwm;
	assign force_b = wr_en && (paddr_i == tocu_pkg::ADDR_CTRL_B) && pwdata_i[tocu_pkg::FORCE_B_POS] && !pwm;

	// next count and overflow condition per family
	always_comb begin
		timer_count_d = timer_count_q;
		count_up_d = count_up_q;
		ovf_evt = 1'b0;
		if (timer_tick) begin
			unique case (wave)
				tocu_pkg::WAVE_NORMAL: begin
					timer_count_d = timer_count_q + tocu_pkg::COUNT_ONE;
					ovf_evt = timer_count_q == tocu_pkg::COUNT_MAX;
				end
				tocu_pkg::WAVE_CTC: begin
					timer_count_d = at_top ? tocu_pkg::COUNT_BOTTOM : timer_count_q + tocu_pkg::COUNT_ONE;
					ovf_evt = timer_count_q == tocu_pkg::COUNT_MAX;
				end
				tocu_pkg::WAVE_FAST: begin
					timer_count_d = at_top ? tocu_pkg::COUNT_BOTTOM : timer_count_q + tocu_pkg::COUNT_ONE;
					ovf_evt = at_top;
				end
				tocu_pkg::WAVE_PHASE: begin
					if (count_up_q) begin
						count_up_d = !at_top;
						timer_count_d = at_top ? timer_count_q - tocu_pkg::COUNT_ONE
							: timer_count_q + tocu_pkg::COUNT_ONE;
					end else begin
						count_up_d = timer_count_q == tocu_pkg::COUNT_BOTTOM;
						timer_count_d = count_up_d ? timer_count_q + tocu_pkg::COUNT_ONE
							: timer_count_q - tocu_pkg::COUNT_ONE;
					end
					ovf_evt = !count_up_q && timer_count_q == tocu_pkg::COUNT_ONE;
				end
			endcase
		end
		if (cnt_wr) begin
			timer_count_d = pwdata_i[7:0];
			ovf_evt = 1'b0;
		end
	end

	// apb handshake: one cycle of setup, ready on the first access cycle
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ready_q <= 1'b0;
			prdata_o <= 32'h0000_0000;
		end else begin
			ready_q <= psel_i && !penable_i && !ready_q;
			if (psel_i && !penable_i && !pwrite_i) begin
				unique case (paddr_i)
					tocu_pkg::ADDR_CTRL_A: prdata_o <= {24'h00_0000, action_a_q, action_b_q, 2'h0, wgm_lo_q};
					// force bits always read as zero
					tocu_pkg::ADDR_CTRL_B: prdata_o <= {24'h00_0000, 4'h0, wgm_hi_q, clock_source_sel_q};
					tocu_pkg::ADDR_COUNT: prdata_o <= {24'h00_0000, timer_count_q};
					tocu_pkg::ADDR_CMP_A: prdata_o <= {24'h00_0000, pwm ? buf_a_q : compare_value_a_q};
					tocu_pkg::ADDR_CMP_B: prdata_o <= {24'h00_0000, pwm ? buf_b_q : compare_value_b_q};
					tocu_pkg::ADDR_MASK: prdata_o <= {29'h0000_0000, mask_q};
					tocu_pkg::ADDR_FLAGS: prdata_o <= {29'h0000_0000, flags_q};
					tocu_pkg::ADDR_PINS: prdata_o <= {28'h000_0000, pins_q};
					default: prdata_o <= 32'h0000_0000;
				endcase
			end
		end
	end

	// unmapped addresses answer with an error, with the same timing
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pslverr_o <= 1'b0;
		end else begin
			pslverr_o <= psel_i && !penable_i && !ready_q && (paddr_i[1:0] != 2'h0 || paddr_i > tocu_pkg::ADDR_PINS);
		end
	end

	assign pready_o = ready_q;

	// control registers; action bits apply at once, no buffering
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wgm_lo_q <= 2'h0;
			wgm_hi_q <= 1'b0;
			clock_source_sel_q <= tocu_pkg::CS_STOP;
			action_a_q <= tocu_pkg::COM_OFF;
			action_b_q <= tocu_pkg::COM_OFF;
			mask_q <= 3'h0;
			pins_q <= 4'h0;
		end else if (wr_en) begin
			if (paddr_i == tocu_pkg::ADDR_CTRL_A) begin
				wgm_lo_q <= pwdata_i[tocu_pkg::WGM_LO_POS +: 2];
				action_a_q <= pwdata_i[tocu_pkg::COM_A_POS +: 2];
				action_b_q <= pwdata_i[tocu_pkg::COM_B_POS +: 2];
			end
			if (paddr_i == tocu_pkg::ADDR_CTRL_B) begin
				clock_source_sel_q <= pwdata_i[tocu_pkg::CS_POS +: 3];
				wgm_hi_q <= pwdata_i[tocu_pkg::WGM_HI_POS];
			end
			if (paddr_i == tocu_pkg::ADDR_MASK) begin
				mask_q <= pwdata_i[2:0];
			end
			if (paddr_i == tocu_pkg::ADDR_PINS) begin
				pins_q <= pwdata_i[3:0];
			end
		end
	end

	// counter, direction and the one-tick match block
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			timer_count_q <= tocu_pkg::REG_RESET;
			count_up_q <= 1'b1;
			block_q <= 1'b0;
		end else begin
			timer_count_q <= timer_count_d;
			count_up_q <= count_up_d;
			// block holds while stopped until the next timer tick
			if (cnt_wr) begin
				block_q <= 1'b1;
			end else if (timer_tick) begin
				block_q <= 1'b0;
			end
		end
	end

	// compare values: direct in non-pwm, buffered and loaded at top in pwm
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			compare_value_a_q <= tocu_pkg::REG_RESET;
			compare_value_b_q <= tocu_pkg::REG_RESET;
			buf_a_q <= tocu_pkg::REG_RESET;
			buf_b_q <= tocu_pkg::REG_RESET;
		end else begin
			if (pwm && timer_tick && at_top && (wave == tocu_pkg::WAVE_FAST || count_up_q)) begin
				compare_value_a_q <= buf_a_q;
				compare_value_b_q <= buf_b_q;
			end
			if (wr_en && paddr_i == tocu_pkg::ADDR_CMP_A) begin
				buf_a_q <= pwdata_i[7:0];
				if (!pwm) begin
					compare_value_a_q <= pwdata_i[7:0];
				end
			end
			if (wr_en && paddr_i == tocu_pkg::ADDR_CMP_B) begin
				buf_b_q <= pwdata_i[7:0];
				if (!pwm) begin
					compare_value_b_q <= pwdata_i[7:0];
				end
			end
		end
	end

	// sticky flags; a set in the clearing cycle wins
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			flags_q <= 3'h0;
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (wr_en && paddr_i == tocu_pkg::ADDR_FLAGS && pwdata_i[i]) begin
					flags_q[i] <= 1'b0;
				end else if (irq_ack_i[i]) begin
					flags_q[i] <= 1'b0;
				end
			end
			if (ovf_evt) begin
				flags_q[tocu_pkg::FLAG_OVF_POS] <= 1'b1;
			end
			if (hit_a) begin
				flags_q[tocu_pkg::FLAG_CMPA_POS] <= 1'b1;
			end
			if (hit_b) begin
				flags_q[tocu_pkg::FLAG_CMPB_POS] <= 1'b1;
			end
		end
	end

	// request lines follow the enabled flags a cycle later
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			irq_o <= 3'h0;
		end else begin
			irq_o <= flags_q & mask_q & ~irq_ack_i;
		end
	end

	// output states; mode changes leave them alone
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			compare_out_state_a_q <= 1'b0;
			compare_out_state_b_q <= 1'b0;
		end else begin
			// force uses current action bits, non-pwm table only
			if (force_a || hit_a) begin
				compare_out_state_a_q <= oc_next(compare_out_state_a_q, action_a_q, wave, count_up_q, wgm_hi_q);
			end
			if (force_b || hit_b) begin
				compare_out_state_b_q <= oc_next(compare_out_state_b_q, action_b_q, wave, count_up_q, 1'b0);
			end
			// fast pwm restores polarity as the counter returns to bottom
			if (bottom_evt && action_a_q[1]) begin
				compare_out_state_a_q <= !action_a_q[0];
			end
			if (bottom_evt && action_b_q[1]) begin
				compare_out_state_b_q <= !action_b_q[0];
			end
		end
	end

	// pin drive: override when action bits nonzero, direction from port bit
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pin_a_o <= 1'b0;
			pin_b_o <= 1'b0;
			pin_a_oe_n_o <= 1'b1;
			pin_b_oe_n_o <= 1'b1;
		end else begin
			pin_a_o <= (action_a_q != tocu_pkg::COM_OFF) ? compare_out_state_a_q : pins_q[tocu_pkg::PORT_A_POS];
			pin_b_o <= (action_b_q != tocu_pkg::COM_OFF) ? compare_out_state_b_q : pins_q[tocu_pkg::PORT_B_POS];
			pin_a_oe_n_o <= !pins_q[tocu_pkg::DIR_A_POS];
			pin_b_oe_n_o <= !pins_q[tocu_pkg::DIR_B_POS];
		end
	end

	// checks
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!arst_n_i);

	flag_a_set_a: assert property (hit_a |=> flags_q[tocu_pkg::FLAG_CMPA_POS])
		else $error("compare flag a not set after match");
	flag_late_a: assert property ($rose(flags_q[tocu_pkg::FLAG_CMPA_POS]) |-> $past(match_a) && $past(timer_tick))
		else $error("compare flag a set without match");
	write_block_a: assert property (cnt_wr ##1 (timer_tick && !cnt_wr) |-> !hit_a && !hit_b)
		else $error("match not blocked after counter write");
	flag_w1c_a: assert property (wr_en && paddr_i == tocu_pkg::ADDR_FLAGS && pwdata_i[1] && !hit_a
		|=> !flags_q[1])
		else $error("write one did not clear flag");
	force_noflag_a: assert property (force_a && !hit_a && !irq_ack_i[1] |=> flags_q[1] == $past(flags_q[1]))
		else $error("force changed compare flag");
	count_prio_a: assert property (cnt_wr |=> timer_count_q == $past(pwdata_i[7:0]))
		else $error("counter write lost");
	normal_wrap_a: assert property (timer_tick && !cnt_wr && wave == tocu_pkg::WAVE_NORMAL
		&& timer_count_q == tocu_pkg::COUNT_MAX |=> timer_count_q == 8'h00 && flags_q[0])
		else $error("normal mode wrap or overflow wrong");
	stopped_hold_a: assert property (clock_source_sel_q == tocu_pkg::CS_STOP && !cnt_wr
		|=> $stable(timer_count_q))
		else $error("counter moved while stopped");
	pin_override_a: assert property (action_a_q != 2'h0 ##1 $stable(action_a_q) |-> pin_a_o == $past(compare_out_state_a_q))
		else $error("pin a not overridden");
	no_action_a: assert property (hit_a && !bottom_evt && !force_a && action_a_q == 2'h0
		|=> $stable(compare_out_state_a_q))
		else $error("output changed with action zero");
	buffer_hold_a: assert property (pwm && !(timer_tick && at_top) |=> $stable(compare_value_a_q))
		else $error("active compare changed away from top");
	irq_raise_a: assert property (flags_q[1] && mask_q[1] && !irq_ack_i[1] |=> irq_o[1])
		else $error("interrupt request not raised");

	match_cov_c: cover property (hit_a ##1 flags_q[1]);
	force_cov_c: cover property (force_b);
	block_cov_c: cover property (cnt_wr ##1 timer_tick && match_a);
	reload_cov_c: cover property (pwm && timer_tick && at_top);
endmodule : tocu_top

// ---- hw/tocu_pkg.sv ----
// constants and types shared by the timer output compare unit
package tocu_pkg;
	// register byte offsets on the apb bus
	localparam logic [7:0] ADDR_CTRL_A = 8'h00;
	localparam logic [7:0] ADDR_CTRL_B = 8'h04;
	localparam logic [7:0] ADDR_COUNT = 8'h08;
	localparam logic [7:0] ADDR_CMP_A = 8'h0C;
	localparam logic [7:0] ADDR_CMP_B = 8'h10;
	localparam logic [7:0] ADDR_MASK = 8'h14;
	localparam logic [7:0] ADDR_FLAGS = 8'h18;
	localparam logic [7:0] ADDR_PINS = 8'h1C;
	// field positions
	localparam int WGM_LO_POS = 0;
	localparam int COM_B_POS = 4;
	localparam int COM_A_POS = 6;
	localparam int CS_POS = 0;
	localparam int WGM_HI_POS = 3;
	localparam int FORCE_B_POS = 6;
	localparam int FORCE_A_POS = 7;
	localparam int FLAG_OVF_POS = 0;
	localparam int FLAG_CMPA_POS = 1;
	localparam int FLAG_CMPB_POS = 2;
	localparam int DIR_A_POS = 0;
	localparam int DIR_B_POS = 1;
	localparam int PORT_A_POS = 2;
	localparam int PORT_B_POS = 3;
	// reset values and counter limits
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] COUNT_MAX = 8'hFF;
	localparam logic [7:0] COUNT_BOTTOM = 8'h00;
	localparam logic [7:0] COUNT_ONE = 8'h01;
	// waveform mode encodings
	localparam logic [2:0] WGM_NORMAL = 3'h0;
	localparam logic [2:0] WGM_PHASE_FF = 3'h1;
	localparam logic [2:0] WGM_CTC = 3'h2;
	localparam logic [2:0] WGM_FAST_FF = 3'h3;
	localparam logic [2:0] WGM_PHASE_OCR = 3'h5;
	localparam logic [2:0] WGM_FAST_OCR = 3'h7;
	// output action encodings
	localparam logic [1:0] COM_OFF = 2'h0;
	localparam logic [1:0] COM_TOGGLE = 2'h1;
	localparam logic [1:0] COM_CLEAR = 2'h2;
	localparam logic [1:0] COM_SET = 2'h3;
	localparam logic [2:0] CS_STOP = 3'h0;
	// counting families
	typedef enum logic [1:0] {WAVE_NORMAL, WAVE_CTC, WAVE_FAST, WAVE_PHASE} tocu_wave_t;
endpackage : tocu_pkg

// ---- test/tocu_pin_model.sv ----
// port pin model with pull-up for the two compare pins
module tocu_pin_model (
	// timer side of each pin
	input wire logic pin_a_i,
	input wire logic pin_a_oe_n_i,
	input wire logic pin_b_i,
	input wire logic pin_b_oe_n_i,
	// resolved pad levels
	output logic pad_a_o,
	output logic pad_b_o
);
	// undriven pads float to the pull-up, never keep the last driven value
	assign pad_a_o = pin_a_oe_n_i ? 1'b1 : pin_a_i;
	assign pad_b_o = pin_b_oe_n_i ? 1'b1 : pin_b_i;
endmodule : tocu_pin_model

// ---- test/test_timer_output_compare_unit.sv ----
// self-checking bench for the timer output compare unit
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin errors++; \
	$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module test_timer_output_compare_unit;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic tick = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [2:0] irq_ack = 3'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [2:0] irq;
	logic pa, pa_oe_n, pb, pb_oe_n, pad_a, pad_b;
	logic [31:0] rv;
	logic err;
	int errors = 0;
	int samples_checked = 0;

	// 125 MHz system clock
	always #4 clk = ~clk;

	tocu_top u_tocu_top (
		.sys_clk_i(clk), .arst_n_i(arst_n), .tick_i(tick),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
		.pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.irq_o(irq), .irq_ack_i(irq_ack),
		.pin_a_o(pa), .pin_a_oe_n_o(pa_oe_n), .pin_b_o(pb), .pin_b_oe_n_o(pb_oe_n)
	);
	tocu_pin_model u_tocu_pin_model (
		.pin_a_i(pa), .pin_a_oe_n_i(pa_oe_n), .pin_b_i(pb), .pin_b_oe_n_i(pb_oe_n),
		.pad_a_o(pad_a), .pad_b_o(pad_b)
	);

	// one apb transfer; request held until pready is seen at an edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h00_0000, d};
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) errors++;
		rv = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		apb(1'b0, a, 8'h00);
		`CHK(rv, {24'h00_0000, e})
	endtask : rdc

	// n timer ticks, one cycle pulse every second cycle
	task automatic ticks(input int n);
		repeat (n) begin
			@(posedge clk);
			tick <= 1'b1;
			@(posedge clk);
			tick <= 1'b0;
		end
	endtask : ticks

	// pad level and enable of channel a once the pin register has caught up
	task automatic pinc(input logic v, input logic oen);
		repeat (2) @(posedge clk);
		`CHK(pad_a, v)
		`CHK(pa_oe_n, oen)
	endtask : pinc

	// same for channel b
	task automatic pinb(input logic v, input logic oen);
		repeat (2) @(posedge clk);
		`CHK(pad_b, v)
		`CHK(pb_oe_n, oen)
	endtask : pinb

	task automatic t_reset();
		for (int i = 0; i < 8; i++) rdc(8'(i * 4), 8'h00);
		pinc(1'b1, 1'b1);
		`CHK(irq, 3'h0)
		// action bits on and port bit high: the pad shows the cleared state
		wr(tocu_pkg::ADDR_CTRL_A, 8'h80);
		wr(tocu_pkg::ADDR_PINS, 8'h05);
		pinc(1'b0, 1'b0);
		wr(tocu_pkg::ADDR_PINS, 8'h00);
		$display("test reset done");
	endtask : t_reset

	task automatic t_force();
		// output state prepared before the pin is turned to output
		wr(tocu_pkg::ADDR_CTRL_A, 8'h80);
		wr(tocu_pkg::ADDR_CTRL_B, 8'h80);
		rdc(tocu_pkg::ADDR_CTRL_B, 8'h00);
		rdc(tocu_pkg::ADDR_FLAGS, 8'h00);
		pinc(1'b1, 1'b1);
		wr(tocu_pkg::ADDR_PINS, 8'h05);
		pinc(1'b0, 1'b0);
		wr(tocu_pkg::ADDR_CTRL_A, 8'hC0);
		wr(tocu_pkg::ADDR_CTRL_B, 8'h80);
		pinc(1'b1, 1'b0);
		wr(tocu_pkg::ADDR_CTRL_A, 8'h40);
		wr(tocu_pkg::ADDR_CTRL_B, 8'h80);
		pinc(1'b0, 1'b0);
		wr(tocu_pkg::ADDR_CTRL_B, 8'h80);
		pinc(1'b1, 1'b0);
		wr(tocu_pkg::ADDR_CTRL_A, 8'h00);
		wr(tocu_pkg::ADDR_CTRL_B, 8'h80);
		wr(tocu_pkg::ADDR_PINS, 8'h01);
		pinc(1'b0, 1'b0);
		wr(tocu_pkg::ADDR_CTRL_A, 8'h40);
		pinc(1'b1, 1'b0);
		// fast pwm: force ignored and state kept across the mode change
		wr(tocu_pkg::ADDR_CTRL_A, 8'h83);
		wr(tocu_pkg::ADDR_CTRL_B, 8'h80);
		pinc(1'b1, 1'b0);
		wr(tocu_pkg::ADDR_CTRL_A, 8'h40);
		// channel b: forced set with port bit low, forced clear with port bit high
		wr(tocu_pkg::ADDR_CTRL_A, 8'h70);
		wr(tocu_pkg::ADDR_CTRL_B, 8'h40);
		wr(tocu_pkg::ADDR_PINS, 8'h02);
		pinb(1'b1, 1'b0);
		wr(tocu_pkg::ADDR_CTRL_A, 8'h60);
		wr(tocu_pkg::ADDR_PINS, 8'h0A);
		wr(tocu_pkg::ADDR_CTRL_B, 8'h40);
		pinb(1'b0, 1'b0);
		$display("test force done");
	endtask : t_force

	task automatic t_count();
		wr(tocu_pkg::ADDR_COUNT, 8'hFD);
		ticks(3);
		rdc(tocu_pkg::ADDR_COUNT, 8'hFD);
		wr(tocu_pkg::ADDR_CTRL_B, 8'h01);
		ticks(2);
		rdc(tocu_pkg::ADDR_COUNT, 8'hFF);
		rdc(tocu_pkg::ADDR_FLAGS, 8'h00);
		ticks(1);
		rdc(tocu_pkg::ADDR_COUNT, 8'h00);
		rdc(tocu_pkg::ADDR_FLAGS, 8'h01);
		// write lands on an edge that also carries a tick
		// tick held one edge longer: the match at the written value is blocked
		tick <= 1'b1;
		wr(tocu_pkg::ADDR_COUNT, 8'h00);
		@(posedge clk);
		tick <= 1'b0;
		rdc(tocu_pkg::ADDR_COUNT, 8'h01);
		$display("test count done");
	endtask : t_count

	task automatic t_match();
		wr(tocu_pkg::ADDR_CTRL_B, 8'h00);
		wr(tocu_pkg::ADDR_CMP_A, 8'h05);
		wr(tocu_pkg::ADDR_MASK, 8'h02);
		// count equal to compare on purpose, to see the blocked match
		wr(tocu_pkg::ADDR_COUNT, 8'h05);
		wr(tocu_pkg::ADDR_FLAGS, 8'h07);
		wr(tocu_pkg::ADDR_CTRL_B, 8'h01);
		ticks(1);
		rdc(tocu_pkg::ADDR_FLAGS, 8'h00);
		wr(tocu_pkg::ADDR_COUNT, 8'h03);
		ticks(2);
		rdc(tocu_pkg::ADDR_FLAGS, 8'h00);
		ticks(1);
		rdc(tocu_pkg::ADDR_FLAGS, 8'h02);
		`CHK(irq, 3'h2)
		wr(tocu_pkg::ADDR_FLAGS, 8'h05);
		rdc(tocu_pkg::ADDR_FLAGS, 8'h02);
		wr(tocu_pkg::ADDR_FLAGS, 8'h02);
		rdc(tocu_pkg::ADDR_FLAGS, 8'h00);
		wr(tocu_pkg::ADDR_COUNT, 8'h04);
		ticks(2);
		@(posedge clk);
		irq_ack <= 3'h2;
		@(posedge clk);
		irq_ack <= 3'h0;
		rdc(tocu_pkg::ADDR_FLAGS, 8'h00);
		`CHK(irq, 3'h0)
		$display("test match done");
	endtask : t_match

	task automatic t_buffer();
		wr(tocu_pkg::ADDR_CTRL_B, 8'h00);
		wr(tocu_pkg::ADDR_CMP_B, 8'h30);
		wr(tocu_pkg::ADDR_CTRL_A, 8'h03);
		wr(tocu_pkg::ADDR_CMP_B, 8'h14);
		rdc(tocu_pkg::ADDR_CMP_B, 8'h14);
		wr(tocu_pkg::ADDR_COUNT, 8'h12);
		wr(tocu_pkg::ADDR_FLAGS, 8'h07);
		wr(tocu_pkg::ADDR_CTRL_B, 8'h01);
		ticks(3);
		rdc(tocu_pkg::ADDR_FLAGS, 8'h00);
		// new value only takes over at the top of the slope
		wr(tocu_pkg::ADDR_COUNT, 8'hFE);
		ticks(23);
		rdc(tocu_pkg::ADDR_FLAGS, 8'h07);
		wr(tocu_pkg::ADDR_CTRL_B, 8'h00);
		wr(tocu_pkg::ADDR_CTRL_A, 8'h00);
		apb(1'b0, 8'h20, 8'h00);
		`CHK(err, 1'b1)
		`CHK(rv, 32'h0000_0000)
		$display("test buffer done");
	endtask : t_buffer

	task automatic report_and_stop();
		$display("checks=%0d mismatches=%0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : report_and_stop

	// main sequence
	initial begin
		repeat (12) @(posedge clk);
		arst_n <= 1'b1;
		t_reset();
		t_force();
		t_count();
		t_match();
		t_buffer();
		report_and_stop();
	end

	// watchdog, far beyond the few hundred cycles the tests need
	initial begin
		#100us;
		errors++;
		report_and_stop();
	end
endmodule : test_timer_output_compare_unit
